// file: dv/ahb_mem_model.sv
`timescale 1ns/1ps
`default_nettype none

module ahb_mem_model #(
   parameter logic [31:0] FILL = 32'h00000000
) (
   // Clock and reset
   input  wire logic        clk,
   input  wire logic        rstn,
   // Master request
   input  wire logic [31:0] haddr,
   input  wire logic [1:0]  htrans,
   input  wire logic        hwrite,
   input  wire logic [31:0] hwdata,
   // Bench controls
   input  wire logic        slow,
   input  wire logic        fail,
   // Response
   output logic      [31:0] hrdata,
   output logic             hready,
   output logic             hresp
);
   logic [31:0] mem [64];
   logic        dp_q;
   logic        wt_q;
   logic        wr_q;
   logic [5:0]  a_q;

   // Known pattern so copies can be told apart: fill value ORed with word index
   initial begin
      for (int i = 0; i < 64; i++) begin
         mem[i] = FILL | 32'(i);
      end
   end

   // Read data is inverted outside a read data phase, so stale values never pass
   assign hready = !(dp_q && wt_q);
   assign hresp  = dp_q && fail;
   assign hrdata = (dp_q && !wr_q) ? mem[a_q] : ~mem[a_q];

   // One wait state per beat when slow; failed writes leave memory alone
   always @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         dp_q <= 1'b0;
         wt_q <= 1'b0;
         wr_q <= 1'b0;
         a_q  <= 6'h00;
      end else begin
         if (dp_q && hready && wr_q && !fail) begin
            mem[a_q] <= hwdata;
         end
         if (hready && htrans == 2'h2) begin
            dp_q <= 1'b1;
            wt_q <= slow;
            wr_q <= hwrite;
            a_q  <= haddr[7:2];
         end else begin
            dp_q <= dp_q && !hready;
            wt_q <= 1'b0;
         end
      end
   end
endmodule

`default_nettype wire

// file: dv/block_copy_engine_tb.sv
`timescale 1ns/1ps
`default_nettype none
`include "dma_mover_defs.svh"

module block_copy_engine_tb;
   logic        clk, rstn, psel, penable, pwrite, pready, pslverr, e, slow, sram_fail;
   logic [6:0]  paddr;
   logic [31:0] pwdata, prdata, v, m1_haddr, m1_hwdata, m1_hrdata, m2_haddr, m2_hwdata, m2_hrdata;
   logic [1:0]  m1_htrans, m2_htrans;
   logic        m1_hwrite, m1_hready, m1_hresp, m2_hwrite, m2_hready, m2_hresp;
   logic [9:0]  irq;
   logic [2:0]  sz1, sz2;
   logic [1:0]  wlog [$];
   int          n_mismatch, checks_done;

   // Clock
   always #20 clk = ~clk;

   block_copy_engine block_copy_engine_i (
      .clk(clk), .rstn(rstn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
      .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .m1_haddr(m1_haddr), .m1_htrans(m1_htrans), .m1_hwrite(m1_hwrite), .m1_hsize(sz1),
      .m1_hwdata(m1_hwdata), .m1_hrdata(m1_hrdata), .m1_hready(m1_hready), .m1_hresp(m1_hresp),
      .m2_haddr(m2_haddr), .m2_htrans(m2_htrans), .m2_hwrite(m2_hwrite), .m2_hsize(sz2),
      .m2_hwdata(m2_hwdata), .m2_hrdata(m2_hrdata), .m2_hready(m2_hready), .m2_hresp(m2_hresp),
      .subsystem_to_fabric_irq(irq));
   ahb_mem_model #(.FILL(32'h5a000000)) sram_mem (
      .clk(clk), .rstn(rstn), .haddr(m1_haddr), .htrans(m1_htrans), .hwrite(m1_hwrite),
      .hwdata(m1_hwdata), .slow(slow), .fail(sram_fail), .hrdata(m1_hrdata),
      .hready(m1_hready), .hresp(m1_hresp));
   ahb_mem_model #(.FILL(32'hd0000000)) ddr_mem (
      .clk(clk), .rstn(rstn), .haddr(m2_haddr), .htrans(m2_htrans), .hwrite(m2_hwrite),
      .hwdata(m2_hwdata), .slow(slow), .fail(1'b0), .hrdata(m2_hrdata),
      .hready(m2_hready), .hresp(m2_hresp));

   // Log the 64-byte region of each accepted write toward the DDR side
   always @(posedge clk) begin
      if (m2_htrans == 2'h2 && m2_hready && m2_hwrite) begin
         wlog.push_back(m2_haddr[7:6]);
      end
   end

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checks_done++;
      if (got !== exp) begin
         n_mismatch++;
         $display("unexpected at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic test_done();
      $display("checks %0d mismatches %0d", checks_done, n_mismatch);
      if (n_mismatch == 0 && checks_done > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask

   // One zero-wait access; request held until the edge that samples ready
   task automatic apb(input logic w, input logic [6:0] a, input logic [31:0] d);
      @(negedge clk);
      psel = 1'b1;
      penable = 1'b0;
      pwrite = w;
      paddr = a;
      pwdata = d;
      @(negedge clk);
      penable = 1'b1;
      @(posedge clk);
      v = prdata;
      e = pslverr;
      @(negedge clk);
      psel = 1'b0;
      penable = 1'b0;
   endtask

   task automatic rdc(input logic [6:0] a, input logic [31:0] x);
      apb(1'b0, a, 32'h0);
      chk(v, x);
   endtask

   // Poll a register until the masked value shows up, bounded
   task automatic wait_for(input logic [6:0] a, input logic [31:0] m, input logic [31:0] x);
      repeat (4) @(negedge clk);
      for (int n = 0; n < 400; n++) begin
         apb(1'b0, a, 32'h0);
         if ((v & m) === x) return;
      end
      n_mismatch++;
      $display("unexpected at %0t: got %h expected %h", $time, v, x);
      test_done();
   endtask

   task automatic t_reset();
      rdc(`REG_EDR, 32'h0000000f);
      rdc(7'h0c, 32'h0);
      rdc(7'h10, 32'h0);
      apb(1'b0, 7'h58, 32'h0);
      chk({31'h0, e}, 32'h1);
      chk({26'h0, sz1, sz2}, 32'h00000012);
      $display("t_reset done");
   endtask

   task automatic t_ddr_to_sram();
      apb(1'b1, 7'h04, 32'h0);
      apb(1'b1, 7'h08, 32'h40);
      apb(1'b1, 7'h0c, 32'h00710066);
      wait_for(`REG_EDR, 32'hf, 32'hf);
      for (int k = 0; k < 25; k++) begin
         chk(sram_mem.mem[16 + k], 32'hd0000000 | k);
      end
      chk(sram_mem.mem[41], 32'h5a000029);
      rdc(7'h10, 32'h0000000a);
      rdc(7'h14, 32'h0);
      rdc(`REG_EDR, 32'h0000100f);
      chk({22'h0, irq}, 32'h300);
      apb(1'b1, `REG_ICR, 32'hfff);
      rdc(7'h10, 32'h0);
      chk({22'h0, irq}, 32'h0);
      $display("t_ddr_to_sram done");
   endtask

   task automatic t_error();
      sram_fail = 1'b1;
      apb(1'b1, 7'h0c, 32'h00210010);
      wait_for(7'h10, 32'h1, 32'h0);
      rdc(7'h10, 32'h4);
      chk({22'h0, irq}, 32'h100);
      sram_fail = 1'b0;
      apb(1'b1, `REG_ICR, 32'hfff);
      rdc(7'h10, 32'h0);
      $display("t_error done");
   endtask

   // Pause descriptor 0 mid-copy, queue the other three, then resume
   task automatic t_pause_rr();
      logic [31:0] p;
      slow = 1'b1;
      wlog.delete();
      apb(1'b1, 7'h08, 32'h0);
      apb(1'b1, 7'h0c, 32'h00010040);
      apb(1'b1, 7'h0c, 32'h00090040);
      repeat (6) @(negedge clk);
      apb(1'b0, 7'h14, 32'h0);
      p = v;
      repeat (20) @(negedge clk);
      rdc(7'h14, p);
      chk({31'h0, p[15:0] != 0 && p[31:16] >= p[15:0] && p[1:0] == 0}, 32'h1);
      for (int i = 1; i < 4; i++) begin
         apb(1'b1, 7'(`DESC_BASE + `DESC_STRIDE * i), 32'h0);
         apb(1'b1, 7'(`DESC_BASE + `DESC_STRIDE * i + 4), 32'h40 * i);
         apb(1'b1, 7'(`DESC_BASE + `DESC_STRIDE * i + 8), 32'h00010008);
      end
      apb(1'b1, 7'h0c, 32'h00010040);
      wait_for(`REG_EDR, 32'hf, 32'hf);
      chk(32'(wlog.size()), 32'd22);
      for (int k = 0; k < 22; k++) begin
         chk({30'h0, wlog[k]}, (k < 16) ? 0 : (k - 16) / 2 + 1);
      end
      for (int k = 0; k < 16; k++) begin
         chk(ddr_mem.mem[k], 32'h5a000000 | k);
      end
      chk({22'h0, irq}, 32'h0);
      apb(1'b1, `REG_ICR, 32'hfff);
      slow = 1'b0;
      $display("t_pause_rr done");
   endtask

   // Main sequence
   initial begin
      clk = 1'b0;
      rstn = 1'b0;
      {psel, penable, pwrite, slow, sram_fail} = 5'h00;
      paddr = 7'h00;
      pwdata = 32'h0;
      n_mismatch = 0;
      checks_done = 0;
      repeat (4) @(negedge clk);
      rstn = 1'b1;
      t_reset();
      t_ddr_to_sram();
      t_error();
      t_pause_rr();
      test_done();
   end
endmodule

`default_nettype wire

// file: dv/dma_mover_props.sv
`timescale 1ns/1ps
`default_nettype none
`include "dma_mover_defs.svh"

module dma_mover_props (
   // Clock and reset
   input wire logic               clk,
   input wire logic               rstn,
   // Configuration port
   input wire logic               psel,
   input wire logic               penable,
   input wire logic               pwrite,
   input wire logic [`APB_AW-1:0] paddr,
   input wire logic [31:0]        pwdata,
   input wire logic               pready,
   input wire logic               pslverr,
   // Master ports
   input wire logic [1:0]         m1_htrans,
   input wire logic               m1_hwrite,
   input wire logic               m1_hready,
   input wire logic [1:0]         m2_htrans,
   input wire logic               m2_hwrite,
   input wire logic               m2_hready,
   input wire logic [31:0]        m2_hwdata,
   // Interrupt vector
   input wire logic [`IRQ_W-1:0]  subsystem_to_fabric_irq
);
   logic wr_acc;
   logic pz_q;
   logic [4:0] run_q;
   logic [1:0] gap_q;

   default clocking @(posedge clk);
   endclocking
   default disable iff (!rstn);

   // A write lands at the access edge
   assign wr_acc = psel && penable && pwrite;

   // Pause bit of descriptor 0; only that one is ever paused by the bench
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         pz_q <= 1'b0;
      end else if (wr_acc && paddr == 7'h0c) begin
         pz_q <= pwdata[`CR_PAUSE];
      end
   end

   // Port 2 beats three cycles apart form one run; any longer gap ends it
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         {run_q, gap_q} <= '0;
      end else if (m2_htrans == 2'h2 && m2_hready) begin
         run_q <= (gap_q == 2'h2) ? run_q + 5'h01 : 5'h01;
         gap_q <= 2'h0;
      end else if (gap_q != 2'h3) begin
         gap_q <= gap_q + 2'h1;
      end
   end

   AST_PREADY_NEXT: assert property (psel && !penable |=> pready)
      else $error("setup not answered in the next cycle");
   AST_PREADY_PULSE: assert property (pready |=> !pready)
      else $error("ready held longer than one cycle");
   AST_SLVERR_PAIR: assert property (pslverr |-> pready)
      else $error("error flag without ready");
   AST_M1_SPACING: assert property (m1_htrans == 2'h2 && m1_hready
                                    |=> (m1_htrans == 2'h0) [*2])
      else $error("port 1 beats closer than three cycles");
   AST_M2_SPACING: assert property (m2_htrans == 2'h2 && m2_hready
                                    |=> (m2_htrans == 2'h0) [*2])
      else $error("port 2 beats closer than three cycles");
   AST_SINGLE_SOURCE: assert property (!(m1_htrans == 2'h2 && !m1_hwrite
                                         && m2_htrans == 2'h2 && !m2_hwrite))
      else $error("both ports reading at once");
   AST_WDATA_STABLE: assert property (m2_htrans == 2'h2 && m2_hwrite && m2_hready ##1 !m2_hready
                                      |=> $stable(m2_hwdata))
      else $error("write data moved during a stalled data phase");
   AST_IRQ_UNUSED: assert property (subsystem_to_fabric_irq[7:0] == 8'h00)
      else $error("unused interrupt line raised");
   AST_IRQ_CLEAR: assert property (wr_acc && paddr == `REG_ICR && pwdata[11:0] == 12'hfff
                                   |=> ##1 subsystem_to_fabric_irq[9:8] == 2'b00)
      else $error("interrupt stayed up after full clear");
   AST_PAUSE_HOLD: assert property (pz_q [*4] |-> m1_htrans == 2'h0 && m2_htrans == 2'h0)
      else $error("beat issued while paused");
   AST_RESUME: assert property ($fell(pz_q) |-> ##[1:8] (m1_htrans == 2'h2
                                                        || m2_htrans == 2'h2))
      else $error("no beat after resume");
   AST_RUN_LIMIT: assert property (run_q <= 5'h0c)
      else $error("more back-to-back beats than the weight");
endmodule

bind block_copy_engine dma_mover_props dma_mover_props_i (
   .clk(clk), .rstn(rstn), .psel(psel), .penable(penable), .pwrite(pwrite),
   .paddr(paddr), .pwdata(pwdata), .pready(pready), .pslverr(pslverr),
   .m1_htrans(m1_htrans), .m1_hwrite(m1_hwrite), .m1_hready(m1_hready),
   .m2_htrans(m2_htrans), .m2_hwrite(m2_hwrite), .m2_hready(m2_hready),
   .m2_hwdata(m2_hwdata), .subsystem_to_fabric_irq(subsystem_to_fabric_irq));

`default_nettype wire

// file: rtl/block_copy_engine.sv
`timescale 1ns/1ps
`default_nettype none
`include "dma_mover_defs.svh"

module block_copy_engine
   import dma_mover_pkg::*;
#(
   parameter int unsigned RR_WEIGHT  = 12,
   parameter int unsigned FIFO_DEPTH = 8
) (
   // Clock and reset
   input  wire logic                 clk,
   input  wire logic                 rstn,
   // Configuration port
   input  wire logic                 psel,
   input  wire logic                 penable,
   input  wire logic                 pwrite,
   input  wire logic [`APB_AW-1:0]   paddr,
   input  wire logic [31:0]          pwdata,
   output logic      [31:0]          prdata,
   output logic                      pready,
   output logic                      pslverr,
   // Master port toward the bus matrix and on-chip SRAM
   output logic      [31:0]          m1_haddr,
   output logic      [1:0]           m1_htrans,
   output logic                      m1_hwrite,
   output logic      [2:0]           m1_hsize,
   output logic      [31:0]          m1_hwdata,
   input  wire logic [31:0]          m1_hrdata,
   input  wire logic                 m1_hready,
   input  wire logic                 m1_hresp,
   // Master port toward the external DDR bridge
   output logic      [31:0]          m2_haddr,
   output logic      [1:0]           m2_htrans,
   output logic                      m2_hwrite,
   output logic      [2:0]           m2_hsize,
   output logic      [31:0]          m2_hwdata,
   input  wire logic [31:0]          m2_hrdata,
   input  wire logic                 m2_hready,
   input  wire logic                 m2_hresp,
   // Interrupt vector toward the fabric
   output logic      [`IRQ_W-1:0]    subsystem_to_fabric_irq
);

   core_state_t   s_q;
   core_state_t   s_d;
   fifo_if #(.W(32)) fb ();

   logic [1:0][31:0] hrdata;
   logic [1:0]       hready;
   logic [1:0]       hresp;
   logic             rp;
   logic             wp;
   logic             paused;
   logic             access;
   logic             found;
   logic             err;
   logic [1:0]       k;
   logic [1:0]       k_try;
   logic [15:0]      cnt;
   logic [3:0]       en_cmp;
   logic [3:0]       en_err;
   logic [3:0]       en_nw;
   reg_sel_t         sel;

   // Staging buffer between the read and the write engine
   data_fifo #(
      .W     (32),
      .DEPTH (FIFO_DEPTH)
   ) u_fifo (
      .clk  (clk),
      .rstn (rstn),
      .port (fb.store)
   );

   // Bus inputs come from logic on this clock, so no synchroniser
   assign hrdata = {m2_hrdata, m1_hrdata};
   assign hready = {m2_hready, m1_hready};
   assign hresp  = {m2_hresp, m1_hresp};

   // Map a register offset to descriptor slot, used for reads and writes
   function automatic reg_sel_t decode(input logic [`APB_AW-1:0] a);
      reg_sel_t r;
      r = '0;
      for (int i = 0; i < `NUM_DESC; i++) begin
         for (int j = 0; j <= `SUB_PTR; j++) begin
            if (a == 7'(`DESC_BASE + i * `DESC_STRIDE + j * `WORD_BYTES)) begin
               r.hit = 1'b1;
               r.idx = 2'(i);
               r.sub = 3'(j);
            end
         end
      end
      return r;
   endfunction

   // Next-state logic for the whole engine
   always_comb begin
      s_d    = s_q;
      rp     = s_q.cr[s_q.cur][`CR_DIR] ? `PORT_DDR : `PORT_SRAM;
      wp     = ~rp;
      paused = s_q.cr[s_q.cur][`CR_PAUSE];
      err    = 1'b0;
      found  = 1'b0;
      k      = '0;
      k_try  = '0;
      cnt    = '0;
      en_cmp = '0;
      en_err = '0;
      en_nw  = '0;
      fb.push_valid = 1'b0;
      fb.push_data  = hrdata[rp];
      fb.pop_ready  = 1'b0;
      fb.flush      = 1'b0;
      s_d.pready    = 1'b0;
      s_d.pslverr   = 1'b0;
      access = psel && penable && s_q.pready;

      // Setup phase: read data is latched so it comes from a flop
      if (psel && !penable) begin
         sel          = decode(paddr);
         s_d.pready   = 1'b1;
         s_d.prdata   = '0;
         s_d.pslverr  = 1'b0;
         if (paddr == `REG_EDR) begin
            for (int i = 0; i < `NUM_DESC; i++) begin
               s_d.prdata[i] = !s_q.cr[i][`CR_VALID];
               s_d.prdata[`EDR_NW_LSB + i] = s_q.nw_pend[i];
            end
         end else if (paddr == `REG_ICR) begin
            s_d.prdata = '0;
         end else if (sel.hit) begin
            case (sel.sub)
               `SUB_SAR: s_d.prdata = s_q.sar[sel.idx];
               `SUB_DAR: s_d.prdata = s_q.dar[sel.idx];
               `SUB_CR:  s_d.prdata = s_q.cr[sel.idx];
               `SUB_SR: begin
                  s_d.prdata[`SR_ACTIVE] = s_q.busy && (s_q.cur == sel.idx);
                  s_d.prdata[`SR_CMP]    = s_q.cmp_pend[sel.idx];
                  s_d.prdata[`SR_ERR]    = s_q.err_pend[sel.idx];
                  s_d.prdata[`SR_NW]     = s_q.nw_pend[sel.idx];
               end
               default: s_d.prdata = {s_q.dst_left[sel.idx], s_q.src_left[sel.idx]};
            endcase
         end else begin
            s_d.pslverr = 1'b1;
         end
      end else begin
         sel = '0;
      end

      // Access phase: writes take effect here, clears before any set
      if (access && pwrite) begin
         sel = decode(paddr);
         if (paddr == `REG_ICR) begin
            s_d.cmp_pend = s_q.cmp_pend & ~pwdata[`ICR_CMP_LSB +: 4];
            s_d.err_pend = s_q.err_pend & ~pwdata[`ICR_ERR_LSB +: 4];
            s_d.nw_pend  = s_q.nw_pend & ~pwdata[`ICR_NW_LSB +: 4];
         end else if (sel.hit && s_q.busy && s_q.cur == sel.idx) begin
            // A running descriptor only accepts its pause bit
            if (sel.sub == `SUB_CR) begin
               s_d.cr[sel.idx][`CR_PAUSE] = pwdata[`CR_PAUSE];
            end
         end else if (sel.hit) begin
            case (sel.sub)
               `SUB_SAR: s_d.sar[sel.idx] = pwdata;
               `SUB_DAR: s_d.dar[sel.idx] = pwdata;
               `SUB_CR: begin
                  s_d.cr[sel.idx] = pwdata & `CR_MASK;
                  cnt = pwdata[`CR_CNT_MSB:0];
                  if (pwdata[`CR_VALID]) begin
                     // Low two count bits are dropped, copy goes on anyway
                     s_d.src_left[sel.idx] = cnt & `CNT_ALIGN;
                     s_d.dst_left[sel.idx] = cnt & `CNT_ALIGN;
                     s_d.nw_pend[sel.idx]  = (cnt[1:0] != 2'h0);
                  end
               end
               default: ;
            endcase
         end
      end

      // Pick the next valid descriptor after the last one served
      if (!s_q.busy) begin
         for (int i = 1; i <= `NUM_DESC; i++) begin
            k_try = s_q.cur + 2'(i);
            if (!found && s_q.cr[k_try][`CR_VALID]) begin
               found = 1'b1;
               k     = k_try;
            end
         end
         if (found) begin
            s_d.busy    = 1'b1;
            s_d.abort   = 1'b0;
            s_d.cur     = k;
            s_d.rd_addr = s_q.sar[k];
            s_d.wr_addr = s_q.dar[k];
         end
      end

      // Read engine: source port into the buffer
      case (s_q.rd_st)
         ENG_IDLE: begin
            if (s_q.busy && !paused && s_q.src_left[s_q.cur] != 16'h0000 &&
                fb.push_ready && s_q.rd_run != 5'(RR_WEIGHT)) begin
               s_d.haddr[rp]  = s_q.rd_addr;
               s_d.htrans[rp] = `HTRANS_NONSEQ;
               s_d.hwrite[rp] = 1'b0;
               s_d.rd_st      = ENG_ADDR;
               s_d.rd_run     = s_q.rd_run + 5'h01;
            end else begin
               // One idle slot hands the bus to other masters
               s_d.rd_run = '0;
            end
         end
         ENG_ADDR: begin
            if (hready[rp]) begin
               s_d.htrans[rp] = `HTRANS_IDLE;
               s_d.rd_st      = ENG_DATA;
            end
         end
         ENG_DATA: begin
            if (hready[rp]) begin
               s_d.rd_st = ENG_IDLE;
               if (hresp[rp]) begin
                  err = 1'b1;
               end else begin
                  fb.push_valid = 1'b1;
                  s_d.rd_addr   = s_q.rd_addr + `ADDR_STEP;
                  s_d.src_left[s_q.cur] = s_q.src_left[s_q.cur] - `WORD_BYTES;
               end
            end
         end
         default: s_d.rd_st = ENG_IDLE;
      endcase

      // Write engine: buffer out to the destination port
      case (s_q.wr_st)
         ENG_IDLE: begin
            if (s_q.busy && !paused && s_q.dst_left[s_q.cur] != 16'h0000 &&
                fb.pop_valid && s_q.wr_run != 5'(RR_WEIGHT)) begin
               s_d.haddr[wp]  = s_q.wr_addr;
               s_d.htrans[wp] = `HTRANS_NONSEQ;
               s_d.hwrite[wp] = 1'b1;
               s_d.hwdata[wp] = fb.pop_data;
               fb.pop_ready   = 1'b1;
               s_d.wr_st      = ENG_ADDR;
               s_d.wr_run     = s_q.wr_run + 5'h01;
            end else begin
               s_d.wr_run = '0;
            end
         end
         ENG_ADDR: begin
            if (hready[wp]) begin
               s_d.htrans[wp] = `HTRANS_IDLE;
               s_d.wr_st      = ENG_DATA;
            end
         end
         ENG_DATA: begin
            if (hready[wp]) begin
               s_d.wr_st = ENG_IDLE;
               if (hresp[wp]) begin
                  err = 1'b1;
               end else begin
                  s_d.wr_addr = s_q.wr_addr + `ADDR_STEP;
                  s_d.dst_left[s_q.cur] = s_q.dst_left[s_q.cur] - `WORD_BYTES;
               end
            end
         end
         default: s_d.wr_st = ENG_IDLE;
      endcase

      // A bus error zeroes both counts; a beat still in flight that completes later decrements its count past zero
      if (err) begin
         s_d.err_pend[s_q.cur] = 1'b1;
         s_d.abort             = 1'b1;
         s_d.src_left[s_q.cur] = '0;
         s_d.dst_left[s_q.cur] = '0;
      end

      // Both counts spent and both engines quiet ends the descriptor
      if (s_q.busy && s_q.rd_st == ENG_IDLE && s_q.wr_st == ENG_IDLE &&
          s_q.src_left[s_q.cur] == 16'h0000 && s_q.dst_left[s_q.cur] == 16'h0000) begin
         s_d.busy                     = 1'b0;
         s_d.cr[s_q.cur][`CR_VALID]   = 1'b0;
         s_d.cmp_pend[s_q.cur]        = !s_q.abort || s_q.cmp_pend[s_q.cur];
         fb.flush                     = 1'b1;
      end

      // Interrupt lines follow the pending flags through their enables
      for (int i = 0; i < `NUM_DESC; i++) begin
         en_cmp[i] = s_d.cr[i][`CR_EN_CMP];
         en_err[i] = s_d.cr[i][`CR_EN_ERR];
         en_nw[i]  = s_d.cr[i][`CR_EN_NW];
      end
      s_d.irq           = '0;
      s_d.irq[`IRQ_CMP] = |(s_d.cmp_pend & en_cmp);
      s_d.irq[`IRQ_ERR] = |(s_d.err_pend & en_err) | |(s_d.nw_pend & en_nw);
   end

   // State register; hsize is fixed at word beats from reset on
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         s_q          <= '0;
         s_q.hsize[0] <= `HSIZE_WORD;
         s_q.hsize[1] <= `HSIZE_WORD;
      end else begin
         s_q <= s_d;
      end
   end

   // Every output is a flop of the state
   assign prdata    = s_q.prdata;
   assign pready    = s_q.pready;
   assign pslverr   = s_q.pslverr;
   assign m1_haddr  = s_q.haddr[0];
   assign m1_htrans = s_q.htrans[0];
   assign m1_hwrite = s_q.hwrite[0];
   assign m1_hsize  = s_q.hsize[0];
   assign m1_hwdata = s_q.hwdata[0];
   assign m2_haddr  = s_q.haddr[1];
   assign m2_htrans = s_q.htrans[1];
   assign m2_hwrite = s_q.hwrite[1];
   assign m2_hsize  = s_q.hsize[1];
   assign m2_hwdata = s_q.hwdata[1];
   assign subsystem_to_fabric_irq = s_q.irq;
endmodule

`default_nettype wire

// file: rtl/data_fifo.sv
`timescale 1ns/1ps
`default_nettype none

module data_fifo #(
   parameter int unsigned W     = 32,
   parameter int unsigned DEPTH = 8
) (
   // Clock and reset
   input wire logic clk,
   input wire logic rstn,
   // Buffer side of the handshake
   fifo_if.store    port
);
   localparam int unsigned AW = $clog2(DEPTH);

   typedef struct packed {
      logic [DEPTH-1:0][W-1:0] mem;
      logic [AW:0]             wp;
      logic [AW:0]             rp;
   } fifo_state_t;

   fifo_state_t s_q;
   fifo_state_t s_d;
   logic        empty;
   logic        full;

   // Extra pointer bit tells a full ring from an empty one
   always_comb begin
      s_d   = s_q;
      empty = (s_q.wp == s_q.rp);
      full  = (s_q.wp[AW-1:0] == s_q.rp[AW-1:0]) && (s_q.wp[AW] != s_q.rp[AW]);
      port.push_ready = !full;
      port.pop_valid  = !empty;
      port.pop_data   = s_q.mem[s_q.rp[AW-1:0]];
      if (port.flush) begin
         s_d.wp = '0;
         s_d.rp = '0;
      end else begin
         if (port.push_valid && !full) begin
            s_d.mem[s_q.wp[AW-1:0]] = port.push_data;
            s_d.wp = s_q.wp + 1'b1;
         end
         if (port.pop_ready && !empty) begin
            s_d.rp = s_q.rp + 1'b1;
         end
      end
   end

   // State register
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         s_q <= '0;
      end else begin
         s_q <= s_d;
      end
   end
endmodule

`default_nettype wire

// file: rtl/dma_mover_defs.svh
`ifndef DMA_MOVER_DEFS_SVH
`define DMA_MOVER_DEFS_SVH

// Register byte offsets, only the low seven address bits are decoded
`define APB_AW       7
`define REG_EDR      7'h00
`define DESC_BASE    7'h04
`define DESC_STRIDE  7'h14
`define REG_ICR      7'h54
`define NUM_DESC     4

// Register slots inside one descriptor block
`define SUB_SAR      3'h0
`define SUB_DAR      3'h1
`define SUB_CR       3'h2
`define SUB_SR       3'h3
`define SUB_PTR      3'h4

// Descriptor control fields
`define CR_CNT_MSB   15
`define CR_DIR       1
`define CR_VALID     16
`define CR_PAUSE     19
`define CR_EN_CMP    20
`define CR_EN_ERR    21
`define CR_EN_NW     22
`define CR_MASK      32'h0079ffff
`define CNT_ALIGN    16'hfffc

// Descriptor status fields
`define SR_ACTIVE    0
`define SR_CMP       1
`define SR_ERR       2
`define SR_NW        3

// Interrupt clear fields, one nibble per flag kind, and the EDR nw flag field
`define ICR_CMP_LSB  0
`define ICR_ERR_LSB  4
`define ICR_NW_LSB   8
`define EDR_NW_LSB   12

// Interrupt vector lines
`define IRQ_W        10
`define IRQ_ERR      8
`define IRQ_CMP      9

// Bus constants
`define HTRANS_IDLE   2'h0
`define HTRANS_NONSEQ 2'h2
`define HSIZE_WORD    3'h2
`define WORD_BYTES    16'h0004
`define ADDR_STEP     32'h00000004
`define PORT_SRAM     1'h0
`define PORT_DDR      1'h1

`endif

// file: rtl/dma_mover_pkg.sv
package dma_mover_pkg;

   // Phase of one single-beat bus transfer
   typedef enum logic [1:0] {
      ENG_IDLE,
      ENG_ADDR,
      ENG_DATA
   } eng_t;

   // Result of decoding a register address
   typedef struct packed {
      logic       hit;
      logic [1:0] idx;
      logic [2:0] sub;
   } reg_sel_t;

   // Whole state of the copy engine
   typedef struct packed {
      logic [3:0][31:0] sar;
      logic [3:0][31:0] dar;
      logic [3:0][31:0] cr;
      logic [3:0][15:0] src_left;
      logic [3:0][15:0] dst_left;
      logic [3:0]       cmp_pend;
      logic [3:0]       err_pend;
      logic [3:0]       nw_pend;
      logic             busy;
      logic             abort;
      logic [1:0]       cur;
      logic [31:0]      rd_addr;
      logic [31:0]      wr_addr;
      eng_t             rd_st;
      eng_t             wr_st;
      logic [4:0]       rd_run;
      logic [4:0]       wr_run;
      logic [1:0][31:0] haddr;
      logic [1:0][1:0]  htrans;
      logic [1:0]       hwrite;
      logic [1:0][2:0]  hsize;
      logic [1:0][31:0] hwdata;
      logic [31:0]      prdata;
      logic             pready;
      logic             pslverr;
      logic [9:0]       irq;
   } core_state_t;

endpackage

// file: rtl/fifo_if.sv
`timescale 1ns/1ps
`default_nettype none

// Staging buffer handshake between the copy engine and its FIFO
interface fifo_if #(parameter int unsigned W = 32);
   logic         push_valid;
   logic         push_ready;
   logic [W-1:0] push_data;
   logic         pop_valid;
   logic         pop_ready;
   logic [W-1:0] pop_data;
   logic         flush;

   modport user  (output push_valid, push_data, pop_ready, flush,
                  input  push_ready, pop_valid, pop_data);
   modport store (input  push_valid, push_data, pop_ready, flush,
                  output push_ready, pop_valid, pop_data);
endinterface

`default_nettype wire
